// ---- clip_thread_dispatch_state.sv ----
// device end: latches descriptor fields and builds per-thread dispatch words
//
// Operation
// - bit 31 one means single program flow
// - binding-table count used only for prefetch
// - software may zero count for big tables
// - bit 17 zero gives normal dispatch priority
// - bit 16 picks initial floating-point rules
// - illegal-opcode enable goes to control bit 12
// - mask-stack enable goes to control bit 11
// - software exception enable goes to bit 13
// - software writes zero into reserved bits
// - scratch base is 1KB offset from base
// - each spawned thread gets own scratch slice
// - slice size code 0..11 means 1KB..2MB
// - software reserves region for all threads
// - constant read length 0..63 register units
// - vertex read length 1..63 register units
// - software never programs vertex length zero
// - vertex read offset in register units
// - first payload register zero to fifteen
// - fifth dword limits active threads, minus one
`timescale 1ns/1ps
module clip_thread_dispatch_state
   import dispatch_state_pkg::*;
#(
   parameter logic [ADDR_W-1:0] GEN_STATE_BASE = 32'h0000_0000
) (
   input  wire logic     clk,
   input  wire logic     arst_n,
   dispatch_state_if.device lnk
);
   // dword one: prefetch count and start mode of spawned threads
   logic [7:0]           bt_cnt_q;
   logic                 prio_q;
   logic                 fp_q;
   // exception enables, kept in descriptor order until dispatch
   logic                 ill_q;
   logic                 mstk_q;
   logic                 swx_q;
   // dword two: scratch area and slice size code
   logic [21:0]          scr_base_q;
   logic [3:0]           scr_size_q;
   // dword three: payload shape
   logic [5:0]           const_len_q;
   logic [5:0]           vtx_len_q;
   logic [5:0]           vtx_off_q;
   logic [3:0]           start_reg_q;
   // dword four: concurrency limit, passed on for the thread counter
   logic [THR_IDX_W-1:0] max_thr_q;
   // status flag and per-spawn dispatch word
   logic                 err_q;
   logic [CR_W-1:0]      cr_q;
   logic [ADDR_W-1:0]    scr_addr_q;
   logic                 ack_q;
   // combinational views that feed the registers above
   logic                 fault_d;
   logic [CR_W-1:0]      cr_d;
   logic [ADDR_W-1:0]    scr_addr_d;

   // codes above the largest legal one clamp, so a bad code stays bounded
   function automatic logic [3:0] clamp_size(input logic [3:0] code);
      clamp_size = (code > SCR_SIZE_MAX) ? SCR_SIZE_MAX : code;
   endfunction : clamp_size

   // byte size of one per-thread slice: 1KB shifted up by the code
   function automatic logic [ADDR_W-1:0] slice_bytes(input logic [3:0] code);
      slice_bytes = ADDR_W'(1) << (KB_SHIFT + int'(clamp_size(code)));
   endfunction : slice_bytes

   // true when any bit under the mask is set; reserved fields must be zero
   function automatic logic rsvd_set(input logic [DW_W-1:0] dw, input logic [DW_W-1:0] mask);
      rsvd_set = |(dw & mask);
   endfunction : rsvd_set

   // thread control word: illegal-opcode and software enables land on bits that differ from the descriptor; mask-stack keeps bit 11
   function automatic logic [CR_W-1:0] cr_word(input logic ill, input logic mstk, input logic swx);
      logic [CR_W-1:0] w;
      w                  = '0;
      w[CR_ILL_OP_BIT]   = ill;
      w[CR_MASK_STK_BIT] = mstk;
      w[CR_SW_EXC_BIT]   = swx;
      cr_word = w;
   endfunction : cr_word

   // start of the slice owned by one slot; the slot is not checked against the limit
   function automatic logic [ADDR_W-1:0] slice_addr(input logic [21:0]          base,
                                                    input logic [3:0]           code,
                                                    input logic [THR_IDX_W-1:0] slot);
      logic [ADDR_W-1:0] area;
      area       = GEN_STATE_BASE + (ADDR_W'(base) << KB_SHIFT);
      slice_addr = area + ADDR_W'(slot) * slice_bytes(code);
   endfunction : slice_addr

   // settings the device cannot honour; behaviour stays defined anyway
   always_comb begin
      fault_d = !lnk.dw1[SINGLE_FLOW_BIT]
              | rsvd_set(lnk.dw1, DW1_RSVD_MASK)
              | rsvd_set(lnk.dw2, DW2_RSVD_MASK)
              | (lnk.dw2[SCR_SIZE_HI:SCR_SIZE_LO] > SCR_SIZE_MAX)
              | (lnk.dw3[VTX_LEN_HI:VTX_LEN_LO] == '0);
   end

   // next dispatch word, always from the descriptor latched before this edge
   always_comb begin
      cr_d       = cr_word(ill_q, mstk_q, swx_q);
      scr_addr_d = slice_addr(scr_base_q, scr_size_q, lnk.spawn_idx);
   end

   // dword one: prefetch count, priority and float mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bt_cnt_q <= 8'h00;
         prio_q   <= 1'b0;
         fp_q     <= 1'b0;
      end else if (lnk.load) begin
         bt_cnt_q <= lnk.dw1[BT_CNT_HI:BT_CNT_LO];
         prio_q   <= lnk.dw1[PRIO_BIT];
         fp_q     <= lnk.dw1[FPMODE_BIT];
      end
   end

   // dword one: exception enables, remapped only at dispatch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ill_q  <= 1'b0;
         mstk_q <= 1'b0;
         swx_q  <= 1'b0;
      end else if (lnk.load) begin
         ill_q  <= lnk.dw1[ILL_OP_BIT];
         mstk_q <= lnk.dw1[MASK_STK_BIT];
         swx_q  <= lnk.dw1[SW_EXC_BIT];
      end
   end

   // dword two: scratch base and slice size code
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scr_base_q <= 22'h00_0000;
         scr_size_q <= 4'h0;
      end else if (lnk.load) begin
         scr_base_q <= lnk.dw2[SCR_BASE_HI:SCR_BASE_LO];
         scr_size_q <= lnk.dw2[SCR_SIZE_HI:SCR_SIZE_LO];
      end
   end

   // dword three: read lengths, offset and first payload register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         const_len_q <= 6'h00;
         vtx_len_q   <= 6'h01;
         vtx_off_q   <= 6'h00;
         start_reg_q <= 4'h0;
      end else if (lnk.load) begin
         const_len_q <= lnk.dw3[CONST_LEN_HI:CONST_LEN_LO];
         vtx_len_q   <= lnk.dw3[VTX_LEN_HI:VTX_LEN_LO];
         vtx_off_q   <= lnk.dw3[VTX_OFF_HI:VTX_OFF_LO];
         start_reg_q <= lnk.dw3[START_REG_HI:START_REG_LO];
      end
   end

   // dword four: active-thread limit, count minus one
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         max_thr_q <= '0;
      end else if (lnk.load) begin
         max_thr_q <= lnk.dw4[MAX_THR_HI:MAX_THR_LO];
      end
   end

   // error flag follows each load, so a clean load clears it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_q <= 1'b0;
      end else if (lnk.load) begin
         err_q <= fault_d;
      end
   end

   // acknowledge follows every spawn by one cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= lnk.spawn;
      end
   end

   // dispatch word held until the next spawn; a load in the same cycle only
   // reaches later spawns, so one thread never mixes two descriptors
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cr_q       <= '0;
         scr_addr_q <= '0;
      end else if (lnk.spawn) begin
         cr_q       <= cr_d;
         scr_addr_q <= scr_addr_d;
      end
   end

   // handshake back to the loader
   assign lnk.spawn_ack                 = ack_q;
   assign lnk.thread_control_subreg_one = cr_q;
   assign lnk.scratch_addr              = scr_addr_q;
   // descriptor fields seen by the dispatcher
   assign lnk.bt_prefetch_cnt           = bt_cnt_q;
   assign lnk.priority_hi               = prio_q;
   assign lnk.fp_alt                    = fp_q;
   assign lnk.const_len                 = const_len_q;
   assign lnk.vtx_len                   = vtx_len_q;
   assign lnk.vtx_off                   = vtx_off_q;
   assign lnk.payload_start_reg         = start_reg_q;
   assign lnk.max_threads_m1            = max_thr_q;
   // status
   assign lnk.cfg_error                 = err_q;
endmodule : clip_thread_dispatch_state

// ---- clip_thread_dispatch_state_bench.sv ----
// bench: loader and decoder joined, plus a decoder fed faulty dwords
`timescale 1ns/1ps
module clip_thread_dispatch_state_bench;
   import dispatch_state_pkg::*;
   localparam logic [ADDR_W-1:0] BASE = 32'h0010_0000;
   logic clk = 1'b0, arst_n = 1'b0, cfg_load = 1'b0, cfg_prio = 1'b0, cfg_fp_alt = 1'b0, spawn_req = 1'b0;
   logic [2:0] cfg_exc_en = 3'h0;
   logic [7:0] cfg_bt_cnt = 8'h00;
   logic [21:0] cfg_scr_base = 22'h00123;
   logic [3:0] cfg_scr_size = 4'h0, cfg_start_reg = 4'h0;
   logic [5:0] cfg_const_len = 6'h00, cfg_vtx_len = 6'h01, cfg_vtx_off = 6'h00;
   logic [THR_IDX_W-1:0] cfg_max_thr_m1 = 5'h00, spawn_slot = 5'h00;
   logic spawn_done;
   logic [CR_W-1:0] spawn_cr;
   logic [ADDR_W-1:0] spawn_scratch;
   int fails = 0, n_checks = 0, cyc = 0;
   dispatch_state_if lnk();
   dispatch_state_if lnk2();
   clip_thread_dispatch_state #(.GEN_STATE_BASE(BASE)) clip_thread_dispatch_state_i (.clk(clk), .arst_n(arst_n),
      .lnk(lnk.device));
   // second decoder: the bench plays a loader that breaks the programming rules
   clip_thread_dispatch_state #(.GEN_STATE_BASE(BASE)) clip_thread_dispatch_state_i2 (.clk(clk), .arst_n(arst_n),
      .lnk(lnk2.device));
   dispatch_state_driver dispatch_state_driver_i (.clk(clk), .arst_n(arst_n), .cfg_load(cfg_load),
      .cfg_bt_cnt(cfg_bt_cnt), .cfg_prio(cfg_prio), .cfg_fp_alt(cfg_fp_alt), .cfg_exc_en(cfg_exc_en),
      .cfg_scr_base(cfg_scr_base), .cfg_scr_size(cfg_scr_size), .cfg_const_len(cfg_const_len),
      .cfg_vtx_len(cfg_vtx_len), .cfg_vtx_off(cfg_vtx_off), .cfg_start_reg(cfg_start_reg),
      .cfg_max_thr_m1(cfg_max_thr_m1), .spawn_req(spawn_req), .spawn_slot(spawn_slot), .spawn_done(spawn_done),
      .spawn_cr(spawn_cr), .spawn_scratch(spawn_scratch), .lnk(lnk.driver));
   dispatch_state_checker #(.GEN_STATE_BASE(BASE)) dispatch_state_checker_i (.clk(clk), .arst_n(arst_n),
      .load(lnk.load), .dw1(lnk.dw1), .dw2(lnk.dw2), .dw3(lnk.dw3), .dw4(lnk.dw4), .spawn(lnk.spawn),
      .spawn_idx(lnk.spawn_idx), .spawn_ack(lnk.spawn_ack), .thread_control_subreg_one(lnk.thread_control_subreg_one),
      .scratch_addr(lnk.scratch_addr), .bt_prefetch_cnt(lnk.bt_prefetch_cnt), .priority_hi(lnk.priority_hi),
      .fp_alt(lnk.fp_alt), .const_len(lnk.const_len), .vtx_len(lnk.vtx_len), .vtx_off(lnk.vtx_off),
      .payload_start_reg(lnk.payload_start_reg), .max_threads_m1(lnk.max_threads_m1), .cfg_error(lnk.cfg_error));
   always #25 clk = ~clk;
   // hang guard, well above the roughly 120 cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [31:0] scr(input logic [4:0] slot, input logic [3:0] sz);
      return BASE + {cfg_scr_base, 10'h000} + (32'(slot) << (10 + ((sz > 4'hB) ? 4'hB : sz)));
   endfunction : scr
   task automatic do_load();
      @(posedge clk);
      cfg_load <= 1'b1;
      @(posedge clk);
      cfg_load <= 1'b0;
      @(posedge clk);
      #1;
   endtask : do_load
   task automatic do_spawn(input logic [4:0] slot, input logic [2:0] exc, input logic [31:0] escr);
      @(posedge clk);
      spawn_req <= 1'b1;
      spawn_slot <= slot;
      @(posedge clk);
      spawn_req <= 1'b0;
      @(posedge clk);
      #1;
      chk(lnk.spawn_ack, 1'b1);
      @(posedge clk);
      #1;
      chk(spawn_done, 1'b1);
      chk(spawn_cr, {2'b00, exc, 11'h000});
      chk(spawn_scratch, escr);
   endtask : do_spawn
   task automatic s_fields();
      cfg_bt_cnt <= 8'hA5;
      cfg_prio <= 1'b1;
      cfg_fp_alt <= 1'b1;
      cfg_exc_en <= 3'h5;
      cfg_scr_size <= 4'h3;
      cfg_const_len <= 6'h3F;
      cfg_vtx_len <= 6'h3F;
      cfg_vtx_off <= 6'h2A;
      cfg_start_reg <= 4'hF;
      cfg_max_thr_m1 <= 5'h01;
      do_load();
      chk(lnk.dw1[31], 1'b1);
      chk((lnk.dw1 & DW1_RSVD_MASK) | (lnk.dw2 & DW2_RSVD_MASK), 32'h0);
      chk({lnk.bt_prefetch_cnt, lnk.priority_hi, lnk.fp_alt}, {8'hA5, 2'b11});
      chk({lnk.const_len, lnk.vtx_len, lnk.vtx_off}, {6'h3F, 6'h3F, 6'h2A});
      chk({lnk.payload_start_reg, lnk.max_threads_m1, lnk.cfg_error}, {4'hF, 5'h01, 1'b0});
      do_spawn(5'h02, 3'h5, scr(5'h02, 4'h3));
      $display("test fields done");
   endtask : s_fields
   task automatic s_exc();
      cfg_prio <= 1'b0;
      cfg_bt_cnt <= 8'h00;
      for (int e = 0; e < 8; e++) begin
         cfg_exc_en <= 3'(e);
         do_load();
         do_spawn(5'(e), 3'(e), scr(5'(e), 4'h3));
      end
      chk({lnk.priority_hi, lnk.bt_prefetch_cnt}, 9'h000);
      $display("test exceptions done");
   endtask : s_exc
   task automatic s_size();
      logic [3:0] sz [3] = '{4'h0, 4'hB, 4'hF};
      cfg_vtx_len <= 6'h00;
      foreach (sz[i]) begin
         cfg_scr_size <= sz[i];
         do_load();
         do_spawn(5'h1F, 3'h7, scr(5'h1F, sz[i]));
      end
      chk({lnk.vtx_len, lnk.cfg_error}, {6'h01, 1'b0});
      $display("test sizes done");
   endtask : s_size
   task automatic s_order();
      @(posedge clk);
      cfg_exc_en <= 3'h0;
      cfg_load <= 1'b1;
      spawn_req <= 1'b1;
      spawn_slot <= 5'h03;
      @(posedge clk);
      cfg_load <= 1'b0;
      spawn_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(spawn_cr, {2'b00, 3'h7, 11'h000});
      do_spawn(5'h03, 3'h0, scr(5'h03, 4'hF));
      $display("test order done");
   endtask : s_order
   task automatic s_fault(input logic [31:0] d1, input logic [31:0] d2, input logic [31:0] d3, input logic exp);
      @(posedge clk);
      lnk2.dw1 <= d1;
      lnk2.dw2 <= d2;
      lnk2.dw3 <= d3;
      lnk2.load <= 1'b1;
      @(posedge clk);
      lnk2.load <= 1'b0;
      @(posedge clk);
      #1;
      chk(lnk2.cfg_error, exp);
      $display("test fault done");
   endtask : s_fault
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   initial begin
      lnk2.load = 1'b0;
      lnk2.dw1 = 32'h8000_0000;
      lnk2.dw2 = 32'h0000_0000;
      lnk2.dw3 = 32'h0000_0800;
      lnk2.dw4 = 32'h0000_0000;
      lnk2.spawn = 1'b0;
      lnk2.spawn_idx = 5'h00;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      s_fields();
      s_exc();
      s_size();
      s_order();
      s_fault(32'h8000_0000, 32'h0000_0000, 32'h0000_0800, 1'b0);
      s_fault(32'h0000_0000, 32'h0000_0000, 32'h0000_0800, 1'b1);
      s_fault(32'h8000_1000, 32'h0000_0000, 32'h0000_0800, 1'b1);
      s_fault(32'h8000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1);
      s_fault(32'h8000_0000, 32'h0000_040B, 32'h0000_0800, 1'b0);
      s_fault(32'h8000_0000, 32'h0000_000F, 32'h0000_0800, 1'b1);
      s_fault(32'h8000_0000, 32'h0000_0010, 32'h0000_0800, 1'b1);
      final_report();
   end
endmodule : clip_thread_dispatch_state_bench

// ---- dispatch_state_checker.sv ----
// assertions on the descriptor link between loader and decoder
`timescale 1ns/1ps
module dispatch_state_checker
   import dispatch_state_pkg::*;
#(
   parameter logic [ADDR_W-1:0] GEN_STATE_BASE = 32'h0000_0000
) (
   input wire logic                 clk,
   input wire logic                 arst_n,
   input wire logic                 load,
   input wire logic [DW_W-1:0]      dw1,
   input wire logic [DW_W-1:0]      dw2,
   input wire logic [DW_W-1:0]      dw3,
   input wire logic [DW_W-1:0]      dw4,
   input wire logic                 spawn,
   input wire logic [THR_IDX_W-1:0] spawn_idx,
   input wire logic                 spawn_ack,
   input wire logic [CR_W-1:0]      thread_control_subreg_one,
   input wire logic [ADDR_W-1:0]    scratch_addr,
   input wire logic [7:0]           bt_prefetch_cnt,
   input wire logic                 priority_hi,
   input wire logic                 fp_alt,
   input wire logic [5:0]           const_len,
   input wire logic [5:0]           vtx_len,
   input wire logic [5:0]           vtx_off,
   input wire logic [3:0]           payload_start_reg,
   input wire logic [THR_IDX_W-1:0] max_threads_m1,
   input wire logic                 cfg_error
);
   logic [DW_W-1:0] d1_q;
   logic [DW_W-1:0] d2_q;
   logic [3:0]      code;
   // shadow copy: a spawn must see the latched dwords, not the live ones
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         d1_q <= 32'h0000_0000;
         d2_q <= 32'h0000_0000;
      end else if (load) begin
         d1_q <= dw1;
         d2_q <= dw2;
      end
   end
   // oversized codes clamp to the largest slice
   assign code = (d2_q[3:0] > SCR_SIZE_MAX) ? SCR_SIZE_MAX : d2_q[3:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_ack; spawn |=> spawn_ack; endproperty
   property p_ack_src; spawn_ack |-> $past(spawn); endproperty
   property p_cr; spawn_ack |-> thread_control_subreg_one == {2'b00, $past(d1_q[SW_EXC_BIT]),
      $past(d1_q[ILL_OP_BIT]), $past(d1_q[MASK_STK_BIT]), 11'h000}; endproperty
   property p_scr; spawn_ack |-> scratch_addr == GEN_STATE_BASE + {$past(d2_q[31:10]), 10'h000}
      + (32'($past(spawn_idx)) << (KB_SHIFT + $past(code))); endproperty
   property p_bt; $past(load) |-> bt_prefetch_cnt == $past(dw1[25:18]) && priority_hi == $past(dw1[17])
      && fp_alt == $past(dw1[16]); endproperty
   property p_len; $past(load) |-> const_len == $past(dw3[30:25]) && vtx_len == $past(dw3[16:11])
      && vtx_off == $past(dw3[9:4]) && payload_start_reg == $past(dw3[3:0])
      && max_threads_m1 == $past(dw4[29:25]);
   endproperty
   property p_err; $past(load) |-> cfg_error == $past(!dw1[31] || |(dw1 & DW1_RSVD_MASK)
      || |(dw2 & DW2_RSVD_MASK) || dw2[3:0] > SCR_SIZE_MAX || dw3[16:11] == 6'h00); endproperty
   property p_hold; !$past(spawn) |-> $stable(thread_control_subreg_one) && $stable(scratch_addr); endproperty
   property p_keep; !$past(load) |-> $stable(bt_prefetch_cnt) && $stable(const_len) && $stable(max_threads_m1);
   endproperty
   a_ack: assert property (p_ack) else $error("spawn not acknowledged");
   a_ack_src: assert property (p_ack_src) else $error("acknowledge without spawn");
   a_cr: assert property (p_cr) else $error("exception bits misplaced");
   a_scr: assert property (p_scr) else $error("scratch slice wrong");
   a_bt: assert property (p_bt) else $error("count or mode fields wrong");
   a_len: assert property (p_len) else $error("payload fields wrong");
   a_err: assert property (p_err) else $error("error flag wrong");
   a_hold: assert property (p_hold) else $error("dispatch word moved");
   a_keep: assert property (p_keep) else $error("fields moved without load");
   c_load: cover property (load);
   c_ack: cover property (spawn_ack);
   c_both: cover property (load && spawn);
endmodule : dispatch_state_checker

// ---- dispatch_state_driver.sv ----
// far end: packs user fields into descriptor dwords and requests spawns
`timescale 1ns/1ps
module dispatch_state_driver
   import dispatch_state_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 cfg_load,
   input  wire logic [7:0]           cfg_bt_cnt,
   input  wire logic                 cfg_prio,
   input  wire logic                 cfg_fp_alt,
   input  wire logic [2:0]           cfg_exc_en,   // {sw, illegal, mask}
   input  wire logic [21:0]          cfg_scr_base,
   input  wire logic [3:0]           cfg_scr_size,
   input  wire logic [5:0]           cfg_const_len,
   input  wire logic [5:0]           cfg_vtx_len,
   input  wire logic [5:0]           cfg_vtx_off,
   input  wire logic [3:0]           cfg_start_reg,
   input  wire logic [THR_IDX_W-1:0] cfg_max_thr_m1,
   input  wire logic                 spawn_req,
   input  wire logic [THR_IDX_W-1:0] spawn_slot,
   output logic                      spawn_done,
   output logic [CR_W-1:0]           spawn_cr,
   output logic [ADDR_W-1:0]         spawn_scratch,
   dispatch_state_if.driver          lnk
);
   logic                 load_q;
   logic [DW_W-1:0]      dw1_q;
   logic [DW_W-1:0]      dw2_q;
   logic [DW_W-1:0]      dw3_q;
   logic [DW_W-1:0]      dw4_q;
   logic                 spawn_q;
   logic [THR_IDX_W-1:0] idx_q;

   // descriptor build; reserved bits zero, bad lengths/codes patched up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         load_q <= 1'b0;
         dw1_q  <= '0;
         dw2_q  <= '0;
         dw3_q  <= '0;
         dw4_q  <= '0;
      end else begin
         load_q <= cfg_load;
         if (cfg_load) begin
            dw1_q <= '0;
            dw1_q[SINGLE_FLOW_BIT]       <= 1'b1;
            dw1_q[BT_CNT_HI:BT_CNT_LO]   <= cfg_bt_cnt;         // caller may pass zero
            dw1_q[PRIO_BIT]              <= cfg_prio;
            dw1_q[FPMODE_BIT]            <= cfg_fp_alt;
            dw1_q[SW_EXC_BIT]            <= cfg_exc_en[2];
            dw1_q[ILL_OP_BIT]            <= cfg_exc_en[1];
            dw1_q[MASK_STK_BIT]          <= cfg_exc_en[0];
            dw2_q <= '0;
            dw2_q[SCR_BASE_HI:SCR_BASE_LO] <= cfg_scr_base;     // region sized by caller
            dw2_q[SCR_SIZE_HI:SCR_SIZE_LO] <= (cfg_scr_size > SCR_SIZE_MAX) ? SCR_SIZE_MAX : cfg_scr_size;
            dw3_q <= '0;
            dw3_q[CONST_LEN_HI:CONST_LEN_LO] <= cfg_const_len;
            dw3_q[VTX_LEN_HI:VTX_LEN_LO]     <= (cfg_vtx_len == 6'h00) ? 6'h01 : cfg_vtx_len;
            dw3_q[VTX_OFF_HI:VTX_OFF_LO]     <= cfg_vtx_off;
            dw3_q[START_REG_HI:START_REG_LO] <= cfg_start_reg;
            dw4_q <= '0;
            dw4_q[MAX_THR_HI:MAX_THR_LO]     <= cfg_max_thr_m1;
         end
      end
   end

   // spawn request and returned dispatch word
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spawn_q       <= 1'b0;
         idx_q         <= '0;
         spawn_done    <= 1'b0;
         spawn_cr      <= '0;
         spawn_scratch <= '0;
      end else begin
         spawn_q    <= spawn_req;
         idx_q      <= spawn_slot;
         spawn_done <= lnk.spawn_ack;
         if (lnk.spawn_ack) begin
            spawn_cr      <= lnk.thread_control_subreg_one;
            spawn_scratch <= lnk.scratch_addr;
         end
      end
   end

   assign lnk.load      = load_q;
   assign lnk.dw1       = dw1_q;
   assign lnk.dw2       = dw2_q;
   assign lnk.dw3       = dw3_q;
   assign lnk.dw4       = dw4_q;
   assign lnk.spawn     = spawn_q;
   assign lnk.spawn_idx = idx_q;
endmodule : dispatch_state_driver

// ---- dispatch_state_if.sv ----
// link between the descriptor loader (driver side) and the dispatch decoder
`timescale 1ns/1ps
interface dispatch_state_if;
   import dispatch_state_pkg::*;
   logic                 load;        // one-cycle pulse: dwords valid
   logic [DW_W-1:0]      dw1;
   logic [DW_W-1:0]      dw2;
   logic [DW_W-1:0]      dw3;
   logic [DW_W-1:0]      dw4;
   logic                 spawn;       // one-cycle spawn request
   logic [THR_IDX_W-1:0] spawn_idx;   // thread slot being spawned
   logic                 spawn_ack;   // one-cycle, dispatch word valid
   logic [CR_W-1:0]      thread_control_subreg_one;
   logic [ADDR_W-1:0]    scratch_addr;
   logic [7:0]           bt_prefetch_cnt;
   logic                 priority_hi;
   logic                 fp_alt;
   logic [5:0]           const_len;
   logic [5:0]           vtx_len;
   logic [5:0]           vtx_off;
   logic [3:0]           payload_start_reg;
   logic [THR_IDX_W-1:0] max_threads_m1;
   logic                 cfg_error;   // level: illegal setting latched
   modport device (input load, dw1, dw2, dw3, dw4, spawn, spawn_idx,
                   output spawn_ack, thread_control_subreg_one, scratch_addr, bt_prefetch_cnt,
                   priority_hi, fp_alt, const_len, vtx_len, vtx_off, payload_start_reg, max_threads_m1,
                   cfg_error);
   modport driver (output load, dw1, dw2, dw3, dw4, spawn, spawn_idx,
                   input spawn_ack, thread_control_subreg_one, scratch_addr, bt_prefetch_cnt,
                   priority_hi, fp_alt, const_len, vtx_len, vtx_off, payload_start_reg, max_threads_m1,
                   cfg_error);
endinterface : dispatch_state_if

// ---- dispatch_state_pkg.sv ----
// shared constants for the clip-stage thread-dispatch state descriptor
package dispatch_state_pkg;
   localparam int DW_W            = 32;
   localparam int ADDR_W          = 32;
   // second dword fields
   localparam int SINGLE_FLOW_BIT = 31;
   localparam int BT_CNT_HI       = 25;
   localparam int BT_CNT_LO       = 18;
   localparam int PRIO_BIT        = 17;
   localparam int FPMODE_BIT      = 16;
   localparam int ILL_OP_BIT      = 13;
   localparam int MASK_STK_BIT    = 11;
   localparam int SW_EXC_BIT      = 7;
   localparam logic [31:0] DW1_RSVD_MASK = 32'h7C00_D07F;
   // third dword fields
   localparam int SCR_BASE_HI     = 31;
   localparam int SCR_BASE_LO     = 10;
   localparam int SCR_SIZE_HI     = 3;
   localparam int SCR_SIZE_LO     = 0;
   localparam logic [3:0]  SCR_SIZE_MAX  = 4'hB;
   localparam logic [31:0] DW2_RSVD_MASK = 32'h0000_03F0;
   localparam int KB_SHIFT        = 10;
   // fourth dword fields
   localparam int CONST_LEN_HI    = 30;
   localparam int CONST_LEN_LO    = 25;
   localparam int VTX_LEN_HI      = 16;
   localparam int VTX_LEN_LO      = 11;
   localparam int VTX_OFF_HI      = 9;
   localparam int VTX_OFF_LO      = 4;
   localparam int START_REG_HI    = 3;
   localparam int START_REG_LO    = 0;
   // fifth dword field
   localparam int MAX_THR_HI      = 29;
   localparam int MAX_THR_LO      = 25;
   // thread control subregister one exception bits
   localparam int CR_ILL_OP_BIT   = 12;
   localparam int CR_MASK_STK_BIT = 11;
   localparam int CR_SW_EXC_BIT   = 13;
   localparam int CR_W            = 16;
   localparam int THR_IDX_W       = 5;
endpackage : dispatch_state_pkg
